/* access_window_checker.v */
/*
  Access window checker: eight fetch and eight load/store windows check
  core requests and flag faults; a placement check watches where the core
  memories and register blocks sit. Registers over Avalon-MM.
  Assumes one clock, synchronous inputs, an Avalon master that holds its
  request until it samples waitrequest low.
*/
`timescale 1ns/1ns
`include "access_window_map.vh"

module access_window_checker
(
  input  wire        clk,
  input  wire        resetn,
  input  wire        clkEn,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        fetchValid,
  input  wire [31:0] fetchAddr,
  input  wire        lsValid,
  input  wire [31:0] lsAddr,
  output reg         fetchChecked_r,
  output reg         fetchFault_r,
  output reg         lsChecked_r,
  output reg         lsFault_r,
  output reg         irq_r
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Merge write data into an old value under byte enables
  function [31:0] byteMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer      k;
    begin
      byteMerge = old;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (be[k])
        begin
          byteMerge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg  [7:0]   fetchWindowEnable_r;      // Fetch window enables
  reg  [7:0]   loadStoreWindowEnable_r;  // Load/store window enables
  reg  [255:0] fetchWindowBase_r;        // Fetch window bases
  reg  [255:0] fetchWindowMask_r;        // Fetch window masks
  reg  [255:0] loadStoreWindowBase_r;    // Load/store window bases
  reg  [255:0] loadStoreWindowMask_r;    // Load/store window masks
  reg  [95:0]  blockStart_r;             // Start address of three blocks
  reg  [29:0]  blockSizeKb_r;            // Sizes of three blocks
  reg  [`IRQ_BITS-1:0] irqStatus_r;      // Sticky event bits
  reg  [`IRQ_BITS-1:0] irqMask_r;        // Interrupt enables
  reg  [31:0]  fetchFaultAddr_r;         // Last faulting fetch address
  reg  [31:0]  lsFaultAddr_r;            // Last faulting data address
  reg  [8:0]   placeStatus_r;            // Registered placement errors
  reg          winIllegalSeen_r;         // Previous illegal-window level
  reg  [`IRQ_BITS-1:0] irqStatus_nxt;    // Next status value
  reg  [31:0]  readMux;                  // Read data selected by address

  // ----------------------------------------------------------------------
  // Window matching and placement checks
  // ----------------------------------------------------------------------
  wire [7:0] fetchLegal;     // Legal fetch pairs
  wire [7:0] lsLegal;        // Legal load/store pairs
  wire       fetchAnyEn;     // Some fetch window active
  wire       fetchHit;       // Fetch address inside a window
  wire       lsAnyEn;        // Some load/store window active
  wire       lsHit;          // Data address inside a window
  wire [2:0] errAlign;       // Per-block alignment error
  wire [2:0] errCross;       // Per-block region crossing
  wire [2:0] errOverlap;     // Per-block overlap

  window_matcher fetchMatch
  (
    .winEnable  (fetchWindowEnable_r),
    .winBase    (fetchWindowBase_r),
    .winMask    (fetchWindowMask_r),
    .addr       (fetchAddr),
    .winLegal   (fetchLegal),
    .anyEnabled (fetchAnyEn),
    .anyHit     (fetchHit)
  );

  window_matcher lsMatch
  (
    .winEnable  (loadStoreWindowEnable_r),
    .winBase    (loadStoreWindowBase_r),
    .winMask    (loadStoreWindowMask_r),
    .addr       (lsAddr),
    .winLegal   (lsLegal),
    .anyEnabled (lsAnyEn),
    .anyHit     (lsHit)
  );

  placement_checker placeCheck
  (
    .blockStart  (blockStart_r),
    .blockSizeKb (blockSizeKb_r),
    .errAlign    (errAlign),
    .errCross    (errCross),
    .errOverlap  (errOverlap)
  );

  // Fault when windows are active and none holds the address
  wire fetchFaultEv = fetchValid && fetchAnyEn && !fetchHit;
  wire lsFaultEv    = lsValid && lsAnyEn && !lsHit;
  // An enabled window with an illegal pair is a rejected configuration
  wire winIllegal   = |(fetchWindowEnable_r & ~fetchLegal)
                    | |(loadStoreWindowEnable_r & ~lsLegal);
  wire [8:0] placeNow = {errOverlap, errCross, errAlign};

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire [1:0] page    = address[7:6];     // Control or window page
  wire [2:0] winIdx  = address[5:3];     // Window number
  wire       isMask  = address[2];       // Mask word of the window
  wire       req     = read || write;    // Request present
  wire       doWrite = write && !waitrequest; // Write takes effect now

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  always @*
  begin
    readMux = 32'h0000_0000;
    case (page)
      `PAGE_FETCH:
      begin
        readMux = isMask ? fetchWindowMask_r[winIdx*32 +: 32]
                         : fetchWindowBase_r[winIdx*32 +: 32];
      end
      `PAGE_LS:
      begin
        readMux = isMask ? loadStoreWindowMask_r[winIdx*32 +: 32]
                         : loadStoreWindowBase_r[winIdx*32 +: 32];
      end
      `PAGE_CTRL:
      begin
        case (address)
          `REG_IRQ_STATUS:   readMux = {28'h000_0000, irqStatus_r};
          `REG_IRQ_MASK:     readMux = {28'h000_0000, irqMask_r};
          `REG_FETCH_FADDR:  readMux = fetchFaultAddr_r;
          `REG_LS_FADDR:     readMux = lsFaultAddr_r;
          `REG_WIN_ENABLE:   readMux = {16'h0000, loadStoreWindowEnable_r, fetchWindowEnable_r};
          `REG_WIN_LEGAL:    readMux = {16'h0000, lsLegal, fetchLegal};
          `REG_PLACE_STATUS: readMux = {23'h00_0000, placeStatus_r};
          `REG_ICCM_START:   readMux = blockStart_r[31:0];
          `REG_ICCM_SIZE:    readMux = {22'h00_0000, blockSizeKb_r[9:0]};
          `REG_TIGHTLY_COUPLED_DATA_MEMORY_START:   readMux = blockStart_r[63:32];
          `REG_TIGHTLY_COUPLED_DATA_MEMORY_SIZE:    readMux = {22'h00_0000, blockSizeKb_r[19:10]};
          `REG_PIC_START:    readMux = blockStart_r[95:64];
          `REG_PIC_SIZE:     readMux = {22'h00_0000, blockSizeKb_r[29:20]};
          default:           readMux = 32'h0000_0000;
        endcase
      end
      default:
      begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Interrupt status: events set, write-one clears, set wins
  // ----------------------------------------------------------------------
  always @*
  begin
    irqStatus_nxt = irqStatus_r;
    if (doWrite && (address == `REG_IRQ_STATUS) && byteenable[0])
    begin
      irqStatus_nxt = irqStatus_nxt & ~writedata[`IRQ_BITS-1:0];
    end
    irqStatus_nxt[`IRQ_FETCH_FAULT] = irqStatus_nxt[`IRQ_FETCH_FAULT] | fetchFaultEv;
    irqStatus_nxt[`IRQ_LS_FAULT]    = irqStatus_nxt[`IRQ_LS_FAULT] | lsFaultEv;
    irqStatus_nxt[`IRQ_WIN_ILLEGAL] = irqStatus_nxt[`IRQ_WIN_ILLEGAL]
                                    | (winIllegal && !winIllegalSeen_r);
    irqStatus_nxt[`IRQ_PLACE_ERR]   = irqStatus_nxt[`IRQ_PLACE_ERR]
                                    | (|(placeNow & ~placeStatus_r));
  end

  // ----------------------------------------------------------------------
  // Bus handshake and register writes
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      waitrequest             <= 1'b1;
      readdata                <= 32'h0000_0000;
      fetchWindowEnable_r     <= `RST_WIN_ENABLE;
      loadStoreWindowEnable_r <= `RST_WIN_ENABLE;
      fetchWindowBase_r       <= {8{`RST_WIN_BASE}};
      fetchWindowMask_r       <= {8{`RST_WIN_MASK}};
      loadStoreWindowBase_r   <= {8{`RST_WIN_BASE}};
      loadStoreWindowMask_r   <= {8{`RST_WIN_MASK}};
      blockStart_r            <= {3{`RST_BLOCK_START}};
      blockSizeKb_r           <= {3{`RST_BLOCK_SIZE}};
      irqMask_r               <= `RST_IRQ_MASK;
    end
    else if (clkEn)
    begin
      // One wait cycle, then one cycle with waitrequest low
      waitrequest <= !(req && waitrequest);
      if (req && waitrequest)
      begin
        readdata <= read ? readMux : 32'h0000_0000;
      end
      if (doWrite)
      begin
        case (page)
          `PAGE_FETCH:
          begin
            if (isMask)
              fetchWindowMask_r[winIdx*32 +: 32] <=
                byteMerge(fetchWindowMask_r[winIdx*32 +: 32], writedata, byteenable);
            else
              fetchWindowBase_r[winIdx*32 +: 32] <=
                byteMerge(fetchWindowBase_r[winIdx*32 +: 32], writedata, byteenable);
          end
          `PAGE_LS:
          begin
            if (isMask)
              loadStoreWindowMask_r[winIdx*32 +: 32] <=
                byteMerge(loadStoreWindowMask_r[winIdx*32 +: 32], writedata, byteenable);
            else
              loadStoreWindowBase_r[winIdx*32 +: 32] <=
                byteMerge(loadStoreWindowBase_r[winIdx*32 +: 32], writedata, byteenable);
          end
          `PAGE_CTRL:
          begin
            case (address)
              `REG_IRQ_MASK:
                if (byteenable[0]) irqMask_r <= writedata[`IRQ_BITS-1:0];
              `REG_WIN_ENABLE:
              begin
                if (byteenable[0]) fetchWindowEnable_r     <= writedata[7:0];
                if (byteenable[1]) loadStoreWindowEnable_r <= writedata[15:8];
              end
              `REG_ICCM_START: blockStart_r[31:0]  <= byteMerge(blockStart_r[31:0], writedata, byteenable);
              `REG_TIGHTLY_COUPLED_DATA_MEMORY_START: blockStart_r[63:32] <= byteMerge(blockStart_r[63:32], writedata, byteenable);
              `REG_PIC_START:  blockStart_r[95:64] <= byteMerge(blockStart_r[95:64], writedata, byteenable);
              `REG_ICCM_SIZE:  if (byteenable[0]) blockSizeKb_r[9:0]   <= writedata[9:0];
              `REG_TIGHTLY_COUPLED_DATA_MEMORY_SIZE:  if (byteenable[0]) blockSizeKb_r[19:10] <= writedata[9:0];
              `REG_PIC_SIZE:   if (byteenable[0]) blockSizeKb_r[29:20] <= writedata[9:0];
              default:
              begin
                // Unmapped, read-only or status (cleared in irqStatus_nxt): write ignored here
              end
            endcase
          end
          default:
          begin
            // Unmapped page: write ignored
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Access checking, fault capture and interrupt
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetchChecked_r   <= 1'b0;
      fetchFault_r     <= 1'b0;
      lsChecked_r      <= 1'b0;
      lsFault_r        <= 1'b0;
      irq_r            <= 1'b0;
      irqStatus_r      <= {`IRQ_BITS{1'b0}};
      fetchFaultAddr_r <= 32'h0000_0000;
      lsFaultAddr_r    <= 32'h0000_0000;
      placeStatus_r    <= 9'h000;
      winIllegalSeen_r <= 1'b0;
    end
    else if (clkEn)
    begin
      fetchChecked_r   <= fetchValid;
      fetchFault_r     <= fetchFaultEv;
      lsChecked_r      <= lsValid;
      lsFault_r        <= lsFaultEv;
      irqStatus_r      <= irqStatus_nxt;
      irq_r            <= |(irqStatus_nxt & irqMask_r);
      placeStatus_r    <= placeNow;
      winIllegalSeen_r <= winIllegal;
      if (fetchFaultEv)
      begin
        fetchFaultAddr_r <= fetchAddr;
      end
      if (lsFaultEv)
      begin
        lsFaultAddr_r <= lsAddr;
      end
    end
  end

endmodule // access_window_checker

/* access_window_map.vh */
/*
  Constants of the access window checker: register byte offsets, field
  positions, reset values and window geometry.
  Assumes inclusion by bare name from each design file that needs it.
*/
`ifndef ACCESS_WINDOW_MAP_VH
`define ACCESS_WINDOW_MAP_VH

// ----------------------------------------------------------------------
// Window geometry
// ----------------------------------------------------------------------
`define WIN_COUNT        8
`define WIN_ALIGN_BITS   6
`define WIN_LOW_ZERO     6'h00
`define WIN_LOW_ONES     6'h3F

// ----------------------------------------------------------------------
// Register byte offsets (low control page)
// ----------------------------------------------------------------------
`define REG_IRQ_STATUS   8'h00
`define REG_IRQ_MASK     8'h04
`define REG_FETCH_FADDR  8'h08
`define REG_LS_FADDR     8'h0C
`define REG_WIN_ENABLE   8'h10
`define REG_WIN_LEGAL    8'h14
`define REG_PLACE_STATUS 8'h18
`define REG_ICCM_START   8'h20
`define REG_ICCM_SIZE    8'h24
`define REG_TIGHTLY_COUPLED_DATA_MEMORY_START   8'h28
`define REG_TIGHTLY_COUPLED_DATA_MEMORY_SIZE    8'h2C
`define REG_PIC_START    8'h30
`define REG_PIC_SIZE     8'h34

// Window pages: address bits [7:6] pick the page, [5:3] the window,
// bit [2] base (0) or mask (1)
`define PAGE_CTRL        2'h0
`define PAGE_FETCH       2'h1
`define PAGE_LS          2'h2

// ----------------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------------
`define IRQ_FETCH_FAULT  0
`define IRQ_LS_FAULT     1
`define IRQ_WIN_ILLEGAL  2
`define IRQ_PLACE_ERR    3
`define IRQ_BITS         4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_WIN_ENABLE   8'h00
`define RST_WIN_BASE     32'h0000_0000
`define RST_WIN_MASK     32'h0000_003F
`define RST_BLOCK_START  32'h0000_0000
`define RST_BLOCK_SIZE   10'h000
`define RST_IRQ_MASK     4'h0

// ----------------------------------------------------------------------
// Placement geometry
// ----------------------------------------------------------------------
`define REGION_SPAN_BITS 28
`define KB_SHIFT         10
`define BLOCK_COUNT      3

`endif

/* window_matcher.v */
/*
  Eight address windows of one kind: legality of each base/mask pair and
  the match of one address against every legal enabled window.
  Assumes flat vectors of bases and masks, window i in bits [32i+31:32i].
*/
`timescale 1ns/1ns
`include "access_window_map.vh"

module window_matcher
(
  input  wire [7:0]   winEnable,   // One enable per window
  input  wire [255:0] winBase,     // Eight base addresses
  input  wire [255:0] winMask,     // Eight masks
  input  wire [31:0]  addr,        // Address under test
  output reg  [7:0]   winLegal,    // Pair i is a legal configuration
  output reg          anyEnabled,  // At least one legal enabled window
  output reg          anyHit       // Address lies in one of them
);

  // ----------------------------------------------------------------------
  // Legality of one base/mask pair
  // ----------------------------------------------------------------------
  function pairLegal;
    input [31:0] b;
    input [31:0] m;
    begin
      pairLegal = (b[`WIN_ALIGN_BITS-1:0] == `WIN_LOW_ZERO)
        && (m[`WIN_ALIGN_BITS-1:0] == `WIN_LOW_ONES)
        && (((m + 32'h0000_0001) & m) == 32'h0000_0000)
        && ((b & m) == 32'h0000_0000);
    end
  endfunction

  integer i;
  reg [31:0] b;   // Base of window under evaluation
  reg [31:0] m;   // Mask of window under evaluation

  // ----------------------------------------------------------------------
  // Evaluate all windows in parallel
  // ----------------------------------------------------------------------
  always @*
  begin
    b          = 32'h0000_0000;
    m          = 32'h0000_0000;
    winLegal   = 8'h00;
    anyEnabled = 1'b0;
    anyHit     = 1'b0;
    for (i = 0; i < `WIN_COUNT; i = i + 1)
    begin
      b           = winBase[i*32 +: 32];
      m           = winMask[i*32 +: 32];
      winLegal[i] = pairLegal(b, m);
      // Only a legal and enabled window takes part in matching
      if (winEnable[i] && winLegal[i])
      begin
        anyEnabled = 1'b1;
        if ((addr | m) == (b | m))
        begin
          anyHit = 1'b1;
        end
      end
    end
  end

endmodule // window_matcher

/* placement_checker.v */
/*
  Placement check of three core blocks (instruction memory, data memory,
  interrupt controller registers) within sixteen regions of 2^28 bytes.
  Assumes start[31:28] is the region and start[27:0] the offset; a size
  of zero kilobytes means the block is absent.
*/
`timescale 1ns/1ns
`include "access_window_map.vh"

module placement_checker
(
  input  wire [95:0] blockStart,  // Three start addresses
  input  wire [29:0] blockSizeKb, // Three sizes in kilobytes
  output reg  [2:0]  errAlign,    // Offset not aligned to its span
  output reg  [2:0]  errCross,    // Block runs past its region end
  output reg  [2:0]  errOverlap   // Block overlaps another block
);

  // ----------------------------------------------------------------------
  // Span in bytes: size rounded up to the next power of two
  // ----------------------------------------------------------------------
  function [32:0] spanOf;
    input [9:0] kb;
    reg   [32:0] sz;
    reg   [32:0] p;
    integer      k;
    begin
      sz = {13'h0000, kb, 10'h000};
      p  = 33'h0_0000_0400;
      for (k = 0; k < 10; k = k + 1)
      begin
        if (p < sz)
        begin
          p = {p[31:0], 1'b0};
        end
      end
      spanOf = p;
    end
  endfunction

  integer i;
  integer j;
  reg [32:0] span [0:2];  // Rounded span of each block
  reg [32:0] lo   [0:2];  // First byte of each block
  reg [32:0] hi   [0:2];  // One past last byte
  reg [2:0]  present;     // Block has a nonzero size

  // ----------------------------------------------------------------------
  // Evaluate alignment, region crossing and overlap
  // ----------------------------------------------------------------------
  always @*
  begin
    errAlign   = 3'h0;
    errCross   = 3'h0;
    errOverlap = 3'h0;
    for (i = 0; i < `BLOCK_COUNT; i = i + 1)
    begin
      present[i] = (blockSizeKb[i*10 +: 10] != 10'h000);
      span[i]    = spanOf(blockSizeKb[i*10 +: 10]);
      // Start is region base plus offset within the region
      lo[i]      = {1'b0, blockStart[i*32 +: 32]};
      hi[i]      = lo[i] + span[i];
      errAlign[i] = present[i]
        && ((lo[i] & (span[i] - 33'h0_0000_0001)) != 33'h0_0000_0000);
      errCross[i] = present[i]
        && ({5'h00, lo[i][27:0]} + span[i] > 33'h0_1000_0000);
    end
    for (i = 0; i < `BLOCK_COUNT; i = i + 1)
    begin
      for (j = 0; j < `BLOCK_COUNT; j = j + 1)
      begin
        if ((i != j) && present[i] && present[j]
            && (lo[i] < hi[j]) && (lo[j] < hi[i]))
        begin
          errOverlap[i] = 1'b1;
        end
      end
    end
  end

endmodule // placement_checker

/* access_window_checker_sva.sv */
/*
  Checker of the access window checker ports: bus answer and check answers.
  Assumes binding to the top module and one clock domain.
*/
`timescale 1ns/1ns
module access_window_checker_sva
(
  input wire clk,
  input wire resetn,
  input wire clkEn,
  input wire read,
  input wire write,
  input wire waitrequest,
  input wire fetchValid,
  input wire lsValid,
  input wire fetchChecked_r,
  input wire fetchFault_r,
  input wire lsChecked_r,
  input wire lsFault_r
);
  // ----------------------------------------
  // Steps of a request
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_fetchReq; clkEn && fetchValid; endsequence
  sequence s_lsReq; clkEn && lsValid; endsequence
  sequence s_busReq; clkEn && (read || write) && waitrequest; endsequence
  sequence s_busDone; !waitrequest ##1 waitrequest; endsequence

  a_fetch_answer: assert property (s_fetchReq |=> fetchChecked_r)
    else $error("fetch answer missing");
  a_fetch_idle: assert property (clkEn && !fetchValid |=> !fetchChecked_r)
    else $error("fetch answer without request");
  a_fetch_fault_pair: assert property (fetchFault_r |-> fetchChecked_r && $past(fetchValid))
    else $error("fetch fault without answer");
  a_ls_answer: assert property (s_lsReq |=> lsChecked_r)
    else $error("load store answer missing");
  a_ls_idle: assert property (clkEn && !lsValid |=> !lsChecked_r)
    else $error("load store answer without request");
  a_ls_fault_pair: assert property (lsFault_r |-> lsChecked_r && $past(lsValid))
    else $error("load store fault without answer");
  a_bus_answer: assert property (s_busReq |=> s_busDone)
    else $error("bus answer not one cycle");
  a_bus_no_answer: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("bus answer without request");
endmodule // access_window_checker_sva

bind access_window_checker access_window_checker_sva chk_u (.*);

/* core_request_model.sv */
/*
  Core request model: fetch and load/store check requests of one cycle.
  Assumes the bench calls issue between bus cycles.
*/
`timescale 1ns/1ns
module core_request_model
(
  input  wire         clk,
  output logic        fetchValid,
  output logic [31:0] fetchAddr,
  output logic        lsValid,
  output logic [31:0] lsAddr
);
  // Idle at start
  initial
  begin
    fetchValid = 1'b0;
    lsValid = 1'b0;
    fetchAddr = 32'h0000_0000;
    lsAddr = 32'h0000_0000;
  end
  // One request for one edge; address inverted after, so no stale match
  task automatic issue(input logic ls, input logic [31:0] a);
    @(posedge clk);
    if (ls) lsAddr <= a;
    else fetchAddr <= a;
    lsValid <= ls;
    fetchValid <= ~ls;
    @(posedge clk);
    lsValid <= 1'b0;
    fetchValid <= 1'b0;
    if (ls) lsAddr <= ~a;
    else fetchAddr <= ~a;
  endtask
endmodule // core_request_model

/* access_window_checker_tb_top.sv */
/*
  Bench of the access window checker: Avalon tasks, one task a scenario.
  Assumes the core request model drives the check ports.
*/
`timescale 1ns/1ns
module access_window_checker_tb_top;
  logic        clk = 0, resetn = 0, clkEn = 1, read = 0, write = 0;
  logic [7:0]  address = 8'h00;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd, fetchAddr, lsAddr;
  logic        waitrequest, fetchValid, lsValid, irq_r;
  logic        fetchChecked_r, fetchFault_r, lsChecked_r, lsFault_r;
  int          failures = 0, checks = 0;

  always #50 clk = ~clk;
  access_window_checker dut_u (.*);
  core_request_model core_u (.*);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // Check request and its one-cycle answer
  task automatic fchk(input logic ls, input logic [31:0] a, input logic f);
    core_u.issue(ls, a);
    #1;
    chk({31'h0, ls ? lsChecked_r : fetchChecked_r}, 32'h0000_0001);
    chk({31'h0, ls ? lsFault_r : fetchFault_r}, {31'h0, f});
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq_r}, {31'h0, e});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rchk(8'h10, 32'h0000_0000);
    rchk(8'h44, 32'h0000_003F);
    bus(1'b1, 8'h14, 32'h0000_0000);
    rchk(8'h14, 32'h0000_FFFF);
    rchk(8'h3C, 32'h0000_0000);
  endtask
  // Legality of window 1, last pair left illegal
  task t_legal;
    logic [31:0] b [6] = '{32'h0000_0040, 32'h1000_0000, 32'h0000_0000,
                           32'h0000_0000, 32'h0000_0040, 32'h0000_0041};
    logic [31:0] m [6] = '{32'h0000_003F, 32'h0FFF_FFFF, 32'h0000_003E,
                           32'h0000_013F, 32'h0000_007F, 32'h0000_003F};
    logic [5:0]  ok = 6'h03;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, 8'h48, b[i]);
      bus(1'b1, 8'h4C, m[i]);
      bus(1'b0, 8'h14, 32'h0000_0000);
      chk({31'h0, rd[1]}, {31'h0, ok[i]});
    end
  endtask
  task t_match;
    fchk(1'b0, 32'h0000_1234, 1'b0);
    bus(1'b1, 8'h40, 32'h2000_0000);
    bus(1'b1, 8'h44, 32'h0000_0FFF);
    bus(1'b1, 8'h10, 32'h0000_0003);
    fchk(1'b0, 32'h2000_0FFC, 1'b0);
    fchk(1'b0, 32'h2000_1000, 1'b1);
    fchk(1'b0, 32'h0000_0041, 1'b1);
    rchk(8'h08, 32'h0000_0041);
    bus(1'b1, 8'h10, 32'h0000_0002);
    fchk(1'b0, 32'h2000_1000, 1'b0);
    bus(1'b1, 8'hB8, 32'h8000_0000);
    bus(1'b1, 8'hBC, 32'h0000_FFFF);
    bus(1'b1, 8'h10, 32'h0000_8000);
    fchk(1'b1, 32'h8000_FFC0, 1'b0);
    fchk(1'b1, 32'h8001_0000, 1'b1);
  endtask
  // Sticky status, mask and level interrupt
  task t_irq;
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk({28'h0, rd[3:0]}, 32'h0000_0007);
    bus(1'b1, 8'h04, 32'h0000_0001);
    irqchk(1'b1);
    bus(1'b1, 8'h00, 32'h0000_000F);
    irqchk(1'b0);
    fchk(1'b1, 32'h0000_0000, 1'b1);
    irqchk(1'b0);
    // Enable low: a faulting request is neither answered nor latched
    @(posedge clk) clkEn <= 1'b0;
    core_u.issue(1'b1, 32'h0000_1000);
    #1;
    chk({31'h0, lsChecked_r}, 32'h0000_0000);
    @(posedge clk) clkEn <= 1'b1;
    rchk(8'h0C, 32'h0000_0000);
  endtask
  task t_place;
    bus(1'b1, 8'h20, 32'h2000_0000);
    bus(1'b1, 8'h24, 32'h0000_0040);
    bus(1'b1, 8'h28, 32'h2001_0000);
    bus(1'b1, 8'h2C, 32'h0000_0030);
    bus(1'b1, 8'h30, 32'h3FFE_0000);
    bus(1'b1, 8'h34, 32'h0000_0080);
    rchk(8'h18, 32'h0000_0000);
    bus(1'b1, 8'h28, 32'h2000_8000);
    rchk(8'h18, 32'h0000_00C2);
    bus(1'b1, 8'h28, 32'h2001_0000);
    bus(1'b1, 8'h30, 32'h3FFF_0000);
    rchk(8'h18, 32'h0000_0024);
    rchk(8'h00, 32'h0000_000A);
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after two reset cycles
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_legal;
    t_match;
    t_irq;
    t_place;
    give_verdict;
  end
  // Watchdog
  initial
  begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule // access_window_checker_tb_top
